// *** design/fcse_pkg.sv ***
// Purpose: shared constants of the flash command and status engine
// Assumes: 50 MHz clock, byte-wide flash with 8 main and 4 secondary sectors
// Notes: time figures kept in their own unit, cycle counts derived from them
package fcse_pkg;
  // ----------------------------------------------------------------
  // bus and array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int LOW_W = 12;
  localparam int NUM_MAIN = 8;
  localparam int NUM_SEC = 4;
  localparam int NUM_SECT = NUM_MAIN + NUM_SEC;
  localparam int CNT_W = 16;
  // ----------------------------------------------------------------
  // instruction bytes and coded-cycle addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_PROG = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_BULK = 8'h10;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [11:0] ADDR_FIRST = 12'h555;
  localparam logic [11:0] ADDR_SECOND = 12'hAAA;
  // ----------------------------------------------------------------
  // identifier-mode read selectors on address bits 6, 1, 0
  // ----------------------------------------------------------------
  localparam int ID_BIT_HI = 6;
  localparam logic [2:0] IDSEL_CODE = 3'h1;
  localparam logic [2:0] IDSEL_PROT = 3'h2;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] PROT_NO = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ----------------------------------------------------------------
  // status byte layout
  // ----------------------------------------------------------------
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int FAIL_BIT = 5;
  localparam int WIN_BIT = 3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SEQ_GAP_US = 80;
  localparam int ERASE_WIN_US = 100;
  localparam int ERASE_WIN_PCT = 120;
  localparam int PROT_HOLD_US = 100;
  localparam int SEQ_GAP_CYC = SEQ_GAP_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_WIN_CYC = ERASE_WIN_US * 1000 * ERASE_WIN_PCT / (100 * CLK_PERIOD_NS);
  localparam int PROT_HOLD_CYC = PROT_HOLD_US * 1000 / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // decoder states and bus phases
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_READ = 4'b0000,
    ST_UNLK1 = 4'b0001,
    ST_UNLK2 = 4'b0010,
    ST_PROG_WAIT = 4'b0011,
    ST_ER_PRE = 4'b0100,
    ST_ER_UNLK1 = 4'b0101,
    ST_ER_UNLK2 = 4'b0110,
    ST_IDENT = 4'b0111,
    ST_PROG_BUSY = 4'b1000,
    ST_ER_WIN = 4'b1001,
    ST_ER_BUSY = 4'b1010,
    ST_SUSPENDED = 4'b1011,
    ST_PROT_HOLD = 4'b1100,
    ST_FAILED = 4'b1101
  } fcse_state_e;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ACT = 2'b01,
    PH_ACK = 2'b10
  } fcse_phase_e;
endpackage

// *** design/fcse_engine.sv ***
// Purpose: flash instruction-sequence decoder and status-bit generator
// Assumes: sector selects and protection come from same-clock decoder logic
// Notes: embedded program/erase algorithms sit outside, driven by pulses
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - sequences start with AA at 555 then 55 at AAA.
// - only low 12 address bits decoded; one sector select must be active.
// - sequence writes never reach the array as plain writes.
// - bad byte or gap time-out abandons sequence, back to read array.
// - read-array mode after reset or reset-flash; reads return array data.
// - identifier mode, bits 0,0,1 on main sector return identifier byte.
// - identifier mode, bits 0,1,0 return 01 protected, 00 unprotected.
// - suspend only during sector erase; other sectors stay usable.
// - resume only acts while suspended, ignored otherwise.
// - program status bit 7 is inverse of data bit 7 until done.
// - polling valid after fourth program or sixth erase write.
// - erase status bit 7 reads 0 until done; after a program during suspend, inverse of that program's data bit 7.
// - program to protected sector is ignored.
// - erase of only protected sectors: status 100 us, no erase.
// - bit 6 toggles on each status read while busy.
// - toggling starts after fourth program or sixth erase write.
// - bit 5 reads 0 normally, 1 after program or erase failure.
// - failure bit stays set until reset-flash.
// - bit 3 reads 0 during erase window, restarts on 30h, then 1.
// - status bits 4, 2, 1, 0 undefined; driven as 0 here.
// - program is unlock, A0 at 555, then data to target.
// - F0 to an active main sector returns to read array.
// - B0 to an active main sector suspends sector erase.
// - 30h to an active main sector resumes suspended erase.
module fcse_engine #(
  parameter logic [fcse_pkg::CNT_W-1:0] SEQ_GAP_CYC = fcse_pkg::CNT_W'(fcse_pkg::SEQ_GAP_CYC),
  parameter logic [fcse_pkg::CNT_W-1:0] ERASE_WIN_CYC = fcse_pkg::CNT_W'(fcse_pkg::ERASE_WIN_CYC),
  parameter logic [fcse_pkg::CNT_W-1:0] PROT_HOLD_CYC = fcse_pkg::CNT_W'(fcse_pkg::PROT_HOLD_CYC),
  // arbitrary identifier value
  parameter logic [7:0] ID_CODE = 8'h5A
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [0:0] sel_i,
  input wire logic [fcse_pkg::ADDR_W-1:0] adr_i,
  input wire logic [7:0] dat_i,
  output logic [7:0] dat_o,
  output logic ack_o,
  input wire logic [fcse_pkg::NUM_MAIN-1:0] main_sector_select,
  input wire logic [fcse_pkg::NUM_SEC-1:0] secondary_sector_select,
  input wire logic [fcse_pkg::NUM_SECT-1:0] sectProtect,
  output logic [fcse_pkg::ADDR_W-1:0] arrAddr,
  output logic [fcse_pkg::NUM_SECT-1:0] arrSect,
  input wire logic [7:0] arrRdData,
  output logic progStart,
  output logic [7:0] progData,
  output logic eraseStart,
  output logic bulkErase,
  output logic [fcse_pkg::NUM_SECT-1:0] eraseMask,
  output logic suspendReq,
  output logic resumeReq,
  input wire logic algoDone,
  input wire logic algoFail
);
  import fcse_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic isOneHot(input logic [NUM_SECT-1:0] v);
    int n;
    n = 0;
    for (int i = 0; i < NUM_SECT; i++) begin
      n = n + int'(v[i]);
    end
    return n == 1;
  endfunction

  function automatic logic isCmd(input logic [7:0] d, input logic [LOW_W-1:0] a,
                                 input logic [7:0] cd, input logic [LOW_W-1:0] ca);
    return (d == cd) && (a == ca);
  endfunction

  fcse_state_e stateR;
  fcse_phase_e phaseR;
  logic [ADDR_W-1:0] adrR;
  logic [7:0] wdatR;
  logic weR;
  logic bselR;
  logic [NUM_SECT-1:0] sectR;
  logic [CNT_W-1:0] timR;
  logic suspR;
  logic failR;
  logic togR;
  logic opProgR;
  logic bulkR;
  logic [NUM_SECT-1:0] maskR;
  logic [7:0] progDataR;
  logic [7:0] datR;
  logic ackR;

  logic act;
  logic selOne;
  logic selMain;
  logic wrEv;
  logic rdEv;
  logic [LOW_W-1:0] lowAdr;
  logic [2:0] idSel;
  logic statusRd;
  logic [7:0] statusByte;
  logic [7:0] rdByte;
  fcse_state_e baseState;
  logic timerOn;
  logic timerExp;
  logic [CNT_W-1:0] timLimit;
  logic winSkip;

  assign act = (phaseR == PH_ACT);
  assign selOne = isOneHot(sectR);
  assign selMain = |sectR[NUM_MAIN-1:0];
  assign wrEv = act && weR && bselR && selOne;
  assign rdEv = act && !weR && selOne;
  assign lowAdr = adrR[LOW_W-1:0];
  assign idSel = {adrR[ID_BIT_HI], adrR[1:0]};
  assign baseState = suspR ? ST_SUSPENDED : ST_READ;
  // bulk erase skips the collection window, leaves it after one cycle
  assign winSkip = (stateR == ST_ER_WIN) && bulkR;

  // ----------------------------------------------------------------
  // classic wishbone slave: latch, act, acknowledge
  // ----------------------------------------------------------------
  // two-cycle answer keeps array read data registered before ack
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phaseR <= PH_IDLE;
      ackR <= 1'b0;
    end else begin
      unique case (phaseR)
        PH_IDLE: begin
          ackR <= 1'b0;
          if (cyc_i && stb_i) begin
            phaseR <= PH_ACT;
          end
        end
        PH_ACT: begin
          ackR <= 1'b1;
          phaseR <= PH_ACK;
        end
        PH_ACK: begin
          ackR <= 1'b0;
          phaseR <= PH_IDLE;
        end
        default: begin
          ackR <= 1'b0;
          phaseR <= PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adrR <= '0;
      wdatR <= BYTE_ZERO;
      weR <= 1'b0;
      bselR <= 1'b0;
      sectR <= '0;
    end else if (phaseR == PH_IDLE && cyc_i && stb_i) begin
      adrR <= adr_i;
      wdatR <= dat_i;
      weR <= we_i;
      bselR <= sel_i[0];
      sectR <= {secondary_sector_select, main_sector_select};
    end
  end

  assign ack_o = ackR;
  assign arrAddr = adrR;
  assign arrSect = sectR;

  // ----------------------------------------------------------------
  // shared timer: byte gap, erase window, protected-erase hold
  // ----------------------------------------------------------------
  always_comb begin
    timerOn = 1'b1;
    timLimit = SEQ_GAP_CYC;
    unique case (stateR)
      ST_UNLK1, ST_UNLK2, ST_PROG_WAIT, ST_ER_PRE, ST_ER_UNLK1, ST_ER_UNLK2: timLimit = SEQ_GAP_CYC;
      ST_ER_WIN: timLimit = ERASE_WIN_CYC;
      ST_PROT_HOLD: timLimit = PROT_HOLD_CYC;
      default: timerOn = 1'b0;
    endcase
  end
  assign timerExp = timerOn && (timR >= timLimit - CNT_W'(1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timR <= '0;
    end else if (!timerOn || wrEv || timerExp || winSkip) begin
      // each counted write restarts the gap and the erase window
      timR <= '0;
    end else begin
      timR <= timR + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // sequence decoder
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateR <= ST_READ;
      suspR <= 1'b0;
      opProgR <= 1'b0;
      bulkR <= 1'b0;
      maskR <= '0;
      progDataR <= BYTE_ZERO;
    end else if (stateR == ST_PROG_BUSY && algoFail) begin
      stateR <= ST_FAILED;
    end else if ((stateR == ST_ER_BUSY) && algoFail) begin
      stateR <= ST_FAILED;
      suspR <= 1'b0;
    end else if (stateR == ST_PROG_BUSY && algoDone) begin
      stateR <= baseState;
    end else if (stateR == ST_ER_BUSY && algoDone) begin
      stateR <= ST_READ;
      suspR <= 1'b0;
      maskR <= '0;
    end else if (timerExp || winSkip) begin
      unique case (stateR)
        ST_ER_WIN: begin
          if ((maskR & ~sectProtect) == '0) begin
            stateR <= ST_PROT_HOLD;
          end else begin
            stateR <= ST_ER_BUSY;
            maskR <= maskR & ~sectProtect;
          end
        end
        ST_PROT_HOLD: begin
          stateR <= ST_READ;
          maskR <= '0;
        end
        default: stateR <= baseState;
      endcase
    end else if (wrEv) begin
      unique case (stateR)
        ST_READ, ST_SUSPENDED: begin
          if (isCmd(wdatR, lowAdr, CMD_UNLOCK1, ADDR_FIRST)) begin
            stateR <= ST_UNLK1;
          end else if (suspR && selMain && wdatR == CMD_RESUME) begin
            stateR <= ST_ER_BUSY;
            suspR <= 1'b0;
          end
        end
        ST_UNLK1: begin
          stateR <= isCmd(wdatR, lowAdr, CMD_UNLOCK2, ADDR_SECOND) ? ST_UNLK2 : baseState;
        end
        ST_UNLK2: begin
          if (isCmd(wdatR, lowAdr, CMD_PROG, ADDR_FIRST)) begin
            stateR <= ST_PROG_WAIT;
          end else if (isCmd(wdatR, lowAdr, CMD_IDENT, ADDR_FIRST)) begin
            stateR <= ST_IDENT;
          end else if (!suspR && isCmd(wdatR, lowAdr, CMD_ERASE, ADDR_FIRST)) begin
            stateR <= ST_ER_PRE;
          end else begin
            stateR <= baseState;
          end
        end
        ST_PROG_WAIT: begin
          // erasing sectors not programmable while suspended
          if ((sectR & sectProtect) != '0 || (suspR && (sectR & maskR) != '0)) begin
            stateR <= baseState;
          end else begin
            // polling from the fourth write on
            stateR <= ST_PROG_BUSY;
            opProgR <= 1'b1;
            progDataR <= wdatR;
          end
        end
        ST_ER_PRE: begin
          stateR <= isCmd(wdatR, lowAdr, CMD_UNLOCK1, ADDR_FIRST) ? ST_ER_UNLK1 : ST_READ;
        end
        ST_ER_UNLK1: begin
          stateR <= isCmd(wdatR, lowAdr, CMD_UNLOCK2, ADDR_SECOND) ? ST_ER_UNLK2 : ST_READ;
        end
        ST_ER_UNLK2: begin
          opProgR <= 1'b0;
          if (isCmd(wdatR, lowAdr, CMD_BULK, ADDR_FIRST)) begin
            bulkR <= 1'b1;
            if (selMain) begin
              maskR <= {{NUM_SEC{1'b0}}, {NUM_MAIN{1'b1}}};
            end else begin
              maskR <= {{NUM_SEC{1'b1}}, {NUM_MAIN{1'b0}}};
            end
            // window never runs for bulk, start straight away
            stateR <= ST_ER_WIN;
          end else if (wdatR == CMD_SECTOR) begin
            bulkR <= 1'b0;
            maskR <= sectR;
            stateR <= ST_ER_WIN;
          end else begin
            stateR <= ST_READ;
          end
        end
        ST_ER_WIN: begin
          if (wdatR == CMD_SECTOR && !bulkR) begin
            maskR <= maskR | sectR;
          end else begin
            stateR <= ST_READ;
            maskR <= '0;
          end
        end
        ST_ER_BUSY: begin
          if (!bulkR && selMain && wdatR == CMD_SUSPEND) begin
            stateR <= ST_SUSPENDED;
            suspR <= 1'b1;
          end
        end
        ST_IDENT, ST_FAILED: begin
          // reset-flash, any other byte also leaves
          stateR <= baseState;
        end
        default: stateR <= stateR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // failure flag and toggle bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      failR <= 1'b0;
    end else if (algoFail) begin
      // failure sets the flag, wins over a clear
      failR <= 1'b1;
    end else if (wrEv && selMain && wdatR == CMD_RESET &&
                 (stateR == ST_READ || stateR == ST_SUSPENDED || stateR == ST_FAILED || stateR == ST_IDENT)) begin
      failR <= 1'b0;
    end
  end

  always_comb begin
    statusRd = 1'b0;
    unique case (stateR)
      ST_PROG_BUSY, ST_ER_WIN, ST_ER_BUSY, ST_PROT_HOLD, ST_FAILED: statusRd = 1'b1;
      ST_SUSPENDED: statusRd = (sectR & maskR) != '0;
      default: statusRd = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      togR <= 1'b0;
    end else if (rdEv && statusRd && stateR != ST_SUSPENDED) begin
      togR <= ~togR;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    statusByte = BYTE_ZERO;
    statusByte[POLL_BIT] = (opProgR && stateR != ST_PROT_HOLD) ? ~progDataR[7] : 1'b0;
    statusByte[TOGGLE_BIT] = togR;
    statusByte[FAIL_BIT] = failR;
    statusByte[WIN_BIT] = (stateR == ST_ER_BUSY) || (stateR == ST_SUSPENDED) || (stateR == ST_PROT_HOLD);
  end

  always_comb begin
    rdByte = arrRdData;
    if (statusRd) begin
      rdByte = statusByte;
    end else if (stateR == ST_IDENT) begin
      if (idSel == IDSEL_CODE && selMain) begin
        rdByte = ID_CODE;
      end else if (idSel == IDSEL_PROT) begin
        rdByte = ((sectR & sectProtect) != '0) ? PROT_YES : PROT_NO;
      end else begin
        rdByte = BYTE_ZERO;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      datR <= BYTE_ZERO;
    end else if (act) begin
      // array data outside sequences; no select reads zero
      datR <= rdEv ? rdByte : BYTE_ZERO;
    end
  end
  assign dat_o = datR;

  // ----------------------------------------------------------------
  // commands to the embedded algorithms
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      progStart <= 1'b0;
      eraseStart <= 1'b0;
      bulkErase <= 1'b0;
      suspendReq <= 1'b0;
      resumeReq <= 1'b0;
      progData <= BYTE_ZERO;
      eraseMask <= '0;
    end else begin
      progStart <= wrEv && stateR == ST_PROG_WAIT && (sectR & sectProtect) == '0 &&
                   !(suspR && (sectR & maskR) != '0);
      if (wrEv && stateR == ST_PROG_WAIT) begin
        progData <= wdatR;
      end
      eraseStart <= (timerExp || winSkip) && stateR == ST_ER_WIN && (maskR & ~sectProtect) != '0;
      if ((timerExp || winSkip) && stateR == ST_ER_WIN) begin
        eraseMask <= maskR & ~sectProtect;
        bulkErase <= bulkR;
      end
      suspendReq <= wrEv && stateR == ST_ER_BUSY && !bulkR && selMain && wdatR == CMD_SUSPEND;
      resumeReq <= wrEv && stateR == ST_SUSPENDED && suspR && selMain && wdatR == CMD_RESUME &&
                   !isCmd(wdatR, lowAdr, CMD_UNLOCK1, ADDR_FIRST);
    end
  end
endmodule // fcse_engine
`default_nettype wire

// *** verif/fcse_engine_chk.sv ***
// Purpose: port checker for fcse_engine
// Assumes: bound from the testbench top file
// Notes: bus timing, pulse widths, reset quiet
`timescale 1ns/10ps
`default_nettype none
module fcse_engine_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] dat_o,
  input wire logic ack_o,
  input wire logic [fcse_pkg::NUM_MAIN-1:0] main_sector_select,
  input wire logic [fcse_pkg::NUM_SEC-1:0] secondary_sector_select,
  input wire logic progStart,
  input wire logic eraseStart,
  input wire logic suspendReq,
  input wire logic resumeReq
);
  import fcse_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |=> !ack_o && !progStart && dat_o == 8'h00) else $error("outputs busy after reset");
  a_ack_timing: assert property ($rose(cyc_i && stb_i) |=> !ack_o ##1 ack_o)
    else $error("ack not two edges after request");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_idle: assert property (!cyc_i |-> !ack_o) else $error("ack without cycle");
  a_unsel_zero: assert property (ack_o && !we_i && main_sector_select == 8'h00
    && secondary_sector_select == 4'h0 |-> dat_o == 8'h00) else $error("data without select");
  a_prog_single: assert property (progStart |=> !progStart) else $error("long program pulse");
  a_erase_single: assert property (eraseStart |=> !eraseStart) else $error("long erase pulse");
  a_susp_excl: assert property (!(suspendReq && resumeReq)) else $error("suspend with resume");
endmodule // fcse_engine_chk
`default_nettype wire

// *** verif/fcse_array_model.sv ***
// Purpose: array and embedded algorithm stand-in
// Assumes: sixteen bytes, index from low address bits
// Notes: failNext high as a run ends makes that run report failure
`timescale 1ns/10ps
`default_nettype none
module fcse_array_model #(
  parameter int BUSY_CYC = 40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [fcse_pkg::ADDR_W-1:0] arrAddr,
  input wire logic progStart,
  input wire logic [7:0] progData,
  input wire logic eraseStart,
  input wire logic suspendReq,
  input wire logic resumeReq,
  input wire logic failNext,
  output logic [7:0] arrRdData,
  output logic algoDone,
  output logic algoFail
);
  import fcse_pkg::*;
  logic [7:0] memR [16];
  logic [7:0] cntR;
  logic [7:0] dataR;
  logic [3:0] idxR;
  logic progR;
  logic heldR;
  assign arrRdData = memR[arrAddr[3:0]];
  always_ff @(posedge clk) begin
    algoDone <= 1'b0;
    algoFail <= 1'b0;
    if (!rst_n) begin
      cntR <= 8'h00;
      heldR <= 1'b0;
      for (int i = 0; i < 16; i++) memR[i] <= 8'hFF;
    end else if (progStart || eraseStart) begin
      cntR <= 8'(BUSY_CYC);
      progR <= progStart;
      idxR <= arrAddr[3:0];
      dataR <= progData;
    end else if (suspendReq || resumeReq) begin
      heldR <= suspendReq;
    end else if (cntR != 8'h00 && !heldR) begin
      cntR <= cntR - 8'h01;
      if (cntR == 8'h01) begin
        algoDone <= !failNext;
        algoFail <= failNext;
        // bits only cleared, erase sets ones
        if (!failNext && progR) memR[idxR] <= memR[idxR] & dataR;
        else if (!failNext) for (int i = 0; i < 16; i++) memR[i] <= 8'hFF;
      end
    end
  end
endmodule // fcse_array_model
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: self-checking bench for fcse_engine
// Assumes: short gap and window parameters
// Notes: every bus wait is bounded
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fcse_pkg::*;
  logic clk, rst_n, cyc, stb, we, failNext, ack, progStart, eraseStart, susp, resm, done, fail, bulkE;
  logic [ADDR_W-1:0] adr, arrAddr;
  logic [7:0] dat, datO, rdData, progData, q, p;
  logic [11:0] selB, prot, eMask;
  int miscompares = 0, compares = 0, suspCnt = 0, resmCnt = 0, ersCnt = 0, n;
  fcse_engine #(.SEQ_GAP_CYC(16'h0014), .ERASE_WIN_CYC(16'h001E), .PROT_HOLD_CYC(16'h0019)) dut (
    .clk, .rst_n, .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(1'b1), .adr_i(adr), .dat_i(dat),
    .dat_o(datO), .ack_o(ack), .main_sector_select(selB[7:0]), .secondary_sector_select(selB[11:8]),
    .sectProtect(prot), .arrAddr, .arrSect(), .arrRdData(rdData), .progStart, .progData,
    .eraseStart, .bulkErase(bulkE), .eraseMask(eMask), .suspendReq(susp), .resumeReq(resm),
    .algoDone(done), .algoFail(fail));
  fcse_array_model model (.clk, .rst_n, .arrAddr, .progStart, .progData, .eraseStart,
    .suspendReq(susp), .resumeReq(resm), .failNext, .arrRdData(rdData), .algoDone(done), .algoFail(fail));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // upper address bits set on purpose: decode must ignore them
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d, input int s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {7'h55, a};
    dat <= d;
    selB <= 12'h001 << s;
    n = 0;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = datO;
    if (n == 20) begin
      miscompares++;
      stop_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic unlk(input int s);
    wb(1, 12'h555, 8'hAA, s);
    wb(1, 12'hAAA, 8'h55, s);
  endtask
  task automatic poll(input logic [11:0] a, input int s, input logic [7:0] e);
    q = 8'hXX;
    for (int i = 0; i < 40 && q !== e; i++) wb(0, a, 8'h00, s);
    chk("settled byte", q, e);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (susp === 1'b1) suspCnt++;
    if (resm === 1'b1) resmCnt++;
    if (eraseStart === 1'b1) ersCnt++;
  end
  initial begin
    {rst_n, cyc, stb, we, failNext} = 5'h00;
    {adr, dat, selB, prot} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(0, 12'h005, 8'h00, 0); chk("array read", q, 8'hFF);
    wb(0, 12'h005, 8'h00, 12); chk("no select", q, 8'h00);
    $display("test reset done");
    unlk(0); wb(1, 12'h555, 8'hA0, 0); wb(1, 12'h005, 8'h3C, 0);
    wb(0, 12'h005, 8'h00, 0); p = q; chk("poll bit", {7'h00, p[7]}, 8'h01);
    wb(0, 12'h005, 8'h00, 0); chk("toggle bit", {7'h00, q[6]}, {7'h00, ~p[6]});
    chk("fail bit", {7'h00, q[5]}, 8'h00);
    poll(12'h005, 0, 8'h3C);
    $display("test program done");
    prot <= 12'h002;
    unlk(1); wb(1, 12'h555, 8'hA0, 1); wb(1, 12'h006, 8'h00, 1);
    wb(0, 12'h006, 8'h00, 1); chk("protected program", q, 8'hFF);
    unlk(0); wb(1, 12'h555, 8'h90, 0);
    wb(0, 12'h001, 8'h00, 0); chk("identifier", q, 8'h5A);
    wb(0, 12'h002, 8'h00, 1); chk("protected", q, 8'h01);
    wb(0, 12'h002, 8'h00, 0); chk("unprotected", q, 8'h00);
    wb(1, 12'h000, 8'hF0, 0); wb(0, 12'h005, 8'h00, 0); chk("after reset byte", q, 8'h3C);
    $display("test identifier done");
    wb(1, 12'h555, 8'hAA, 0); wb(1, 12'hAAA, 8'h12, 0);
    wb(1, 12'h555, 8'hA0, 0); wb(1, 12'h007, 8'h00, 0);
    wb(0, 12'h007, 8'h00, 0); chk("bad byte", q, 8'hFF);
    wb(1, 12'h555, 8'hAA, 0); repeat (25) @(posedge clk); wb(1, 12'hAAA, 8'h55, 0);
    wb(1, 12'h555, 8'hA0, 0); wb(1, 12'h008, 8'h00, 0);
    wb(0, 12'h008, 8'h00, 0); chk("gap timeout", q, 8'hFF);
    wb(1, 12'h000, 8'h30, 0); wb(1, 12'h000, 8'hB0, 0);
    chk("stray resume", 8'(resmCnt + suspCnt), 8'h00);
    $display("test abandon done");
    unlk(0); wb(1, 12'h555, 8'h80, 0); unlk(0); wb(1, 12'h000, 8'h30, 0);
    wb(0, 12'h000, 8'h00, 0); chk("window open", {7'h00, q[3]}, 8'h00);
    chk("erase poll", {7'h00, q[7]}, 8'h00);
    wb(1, 12'h000, 8'h30, 2);
    repeat (40) @(posedge clk);
    wb(0, 12'h000, 8'h00, 0); chk("window shut", {7'h00, q[3]}, 8'h01);
    wb(1, 12'h000, 8'hB0, 0); chk("suspend", 8'(suspCnt), 8'h01);
    wb(1, 12'h000, 8'h30, 0); chk("resume", 8'(resmCnt), 8'h01);
    poll(12'h005, 0, 8'hFF);
    chk("erase mask", eMask[7:0], 8'h05);
    $display("test erase done");
    unlk(1); wb(1, 12'h555, 8'h80, 1); unlk(1); wb(1, 12'h000, 8'h30, 1);
    repeat (35) @(posedge clk);
    wb(0, 12'h000, 8'h00, 1); chk("hold poll", {7'h00, q[7]}, 8'h00);
    chk("hold window", {7'h00, q[3]}, 8'h01);
    poll(12'h000, 1, 8'hFF);
    chk("erase starts", 8'(ersCnt), 8'h01);
    $display("test protected erase done");
    unlk(2); wb(1, 12'h555, 8'h80, 2); unlk(2); wb(1, 12'h555, 8'h10, 2);
    wb(1, 12'h000, 8'hB0, 2); chk("bulk no suspend", 8'(suspCnt), 8'h01);
    poll(12'h004, 2, 8'hFF);
    chk("bulk flag", {7'h00, bulkE}, 8'h01);
    chk("bulk mask", eMask[7:0], 8'hFD);
    chk("bulk starts", 8'(ersCnt), 8'h02);
    $display("test bulk done");
    failNext <= 1'b1;
    unlk(0); wb(1, 12'h555, 8'hA0, 0); wb(1, 12'h009, 8'h00, 0);
    repeat (45) @(posedge clk);
    wb(0, 12'h009, 8'h00, 0); chk("fail set", {7'h00, q[5]}, 8'h01);
    wb(0, 12'h009, 8'h00, 0); chk("fail held", {7'h00, q[5]}, 8'h01);
    // failed sector 0 left alone, sector 2 used instead
    wb(1, 12'h000, 8'hF0, 2); wb(0, 12'h009, 8'h00, 2); chk("fail cleared", q, 8'hFF);
    $display("test failure done");
    stop_test();
  end
endmodule // testbench
bind fcse_engine fcse_engine_chk u_chk (.clk, .rst_n, .cyc_i, .stb_i, .we_i, .dat_o, .ack_o,
  .main_sector_select, .secondary_sector_select, .progStart, .eraseStart, .suspendReq, .resumeReq);
`default_nettype wire
